/* logic/tsm_pkg.sv */
// Package for the time setpoint matcher: register map, field layout,
// reset values, equation source numbering and the carrier structs.
// Assumes a 32-bit AXI4-Lite register bus and an external calendar counter.
package tsm_pkg;

  // Register byte offsets
  localparam logic [7:0] DAILY0_OFF = 8'h00;
  localparam logic [7:0] DAILY1_OFF = 8'h04;
  localparam logic [7:0] ACTIVE_OFF = 8'h08;
  localparam logic [7:0] WEEK_OFF = 8'h0C;
  localparam logic [7:0] STATUS_OFF = 8'h10;
  localparam logic [7:0] TIME_OFF = 8'h14;
  localparam logic [7:0] EQN_BASE = 8'h40;

  // Field positions inside the time registers
  localparam int DAY_LSB = 24;
  localparam int HOUR_LSB = 16;
  localparam int MIN_LSB = 8;
  localparam int SEC_LSB = 0;
  localparam int WDAY_LSB = 21;

  // Field positions inside an equation register
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 8;
  localparam int SEL_C_LSB = 16;
  localparam int INV_LSB = 24;

  // Field positions inside the status register
  localparam int ST_SP_LSB = 0;
  localparam int ST_AUX_LSB = 8;
  localparam int ST_LINK_LSB = 16;
  localparam int ST_IND_LSB = 24;

  // Bounds of the time fields
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [4:0] DAY_MIN = 5'h01;
  localparam logic [4:0] DAY_MAX = 5'h1F;

  // Reset values
  localparam logic [4:0] DAILY0_HOUR_RST = 5'h08;
  localparam logic [4:0] DAILY1_HOUR_RST = 5'h11;
  localparam logic [5:0] DAILY_MIN_RST = 6'h00;
  localparam logic [5:0] DAILY_SEC_RST = 6'h00;
  localparam logic [4:0] ACT_DAY_RST = 5'h01;
  localparam logic [4:0] ACT_HOUR_RST = 5'h0C;
  localparam logic [5:0] ACT_MIN_RST = 6'h00;
  localparam logic [5:0] ACT_SEC_RST = 6'h00;
  // Monday is bit 0, Sunday bit 6: weekdays on, weekend off
  localparam logic [6:0] WEEK_EN_RST = 7'h1F;

  // Flag counts and equation source numbering
  localparam int N_AUX = 8;
  localparam int N_LINK = 5;
  localparam int N_IND = 8;
  localparam int N_EQN = N_AUX + N_LINK + N_IND;
  localparam int N_EXT = 7;
  localparam int SRC_W = 6;
  localparam int SRC_N = 64;
  localparam int SRC_FALSE = 0;
  localparam int SRC_TRUE = 1;
  localparam int SRC_SP = 2;
  localparam int SRC_EXT = 9;
  localparam int SRC_FLAG = 16;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Current date and time from the calendar counter; wday 0 is Monday
  typedef struct packed {
    logic [4:0] day;
    logic [2:0] wday;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tsm_cal_t;

  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tsm_hms_t;

  typedef struct packed {
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } tsm_active_t;

  // One equation: ((a ^ inv0) & (b ^ inv1)) & (c ^ inv2)
  typedef struct packed {
    logic [2:0] inv;
    logic [SRC_W-1:0] sel_c;
    logic [SRC_W-1:0] sel_b;
    logic [SRC_W-1:0] sel_a;
  } tsm_eqn_t;

  // Default equation (0 & 1) & 1, always false
  localparam tsm_eqn_t EQN_RST = '{inv: 3'h0, sel_c: 6'h01, sel_b: 6'h01, sel_a: 6'h00};

  // Setpoint outputs toward the equation engine
  typedef struct packed {
    logic weekly;
    logic act_sec;
    logic act_min;
    logic act_hour;
    logic act_day;
    logic [1:0] daily_pulse;
  } tsm_sp_out_t;

endpackage : tsm_pkg

/* logic/tsm_eqn.sv */
// One equation of the equation engine: three selected sources, each
// optionally inverted, combined by AND.
// Assumes the source vector is registered by the caller, so no loops form.
`timescale 1ns/1ns
module tsm_eqn (
  input tsm_pkg::tsm_eqn_t cfg,
  input wire logic [tsm_pkg::SRC_N-1:0] src,
  output logic result
);

  logic term_a;
  logic term_b;
  logic term_c;

  // Operand selection, inversion per operand
  assign term_a = src[cfg.sel_a] ^ cfg.inv[0];
  assign term_b = src[cfg.sel_b] ^ cfg.inv[1];
  assign term_c = src[cfg.sel_c] ^ cfg.inv[2];
  assign result = (term_a & term_b) & term_c; // [RL13]

endmodule : tsm_eqn

/* logic/tsm_top.sv */
// Time setpoint matcher: daily, active and weekly setpoints compared
// against the calendar, plus auxiliary, shared link and indicator flags.
// Assumes the calendar counter runs on aclk; discrete pins are asynchronous.
//
// What this block does
// [RL1] Two daily setpoints pulse at matching time
// [RL2] Daily hour 0-23, resets 8 and 17
// [RL3] Daily minute 0-59, resets to 0
// [RL4] Daily second 0-59, resets to 0
// [RL5] Active day true all day, 1-31
// [RL6] Active hour true whole hour, resets 12
// [RL7] Active minute true whole minute, resets 0
// [RL8] Active second true during that second
// [RL9] Day, hour, minute, second outputs kept separate
// [RL10] Weekly output true on enabled weekdays
// [RL11] Monday, Tuesday enables reset to on
// [RL12] Midweek on, weekend off after reset
// [RL13] Auxiliary flags from equations, default false
// [RL14] Indicators drive LEDs unless display variant
// [RL15] Eight indicator flags, each own equation
// [RL16] Calendar external, compared on every clock
`timescale 1ns/1ns
module tsm_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input tsm_pkg::tsm_cal_t cal,
  input wire logic [tsm_pkg::N_EXT-1:0] eng_in,
  input wire logic display_variant,
  output tsm_pkg::tsm_sp_out_t sp_out,
  output logic [tsm_pkg::N_AUX-1:0] aux_flag,
  output logic [tsm_pkg::N_LINK-1:0] shared_link_flag_n,
  output logic [tsm_pkg::N_IND-1:0] indicator_flag_n,
  output logic [tsm_pkg::N_IND-1:0] led
);

  // Configuration state
  tsm_pkg::tsm_hms_t daily_q [2];
  tsm_pkg::tsm_active_t act_q;
  logic [6:0] week_en_q;
  tsm_pkg::tsm_eqn_t eqn_q [tsm_pkg::N_EQN];

  // Bus state
  logic awready_q;
  logic wready_q;
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Setpoint and flag state
  logic [1:0] daily_hit_q;
  tsm_pkg::tsm_sp_out_t sp_q;
  logic [tsm_pkg::N_EQN-1:0] flag_q;
  logic [tsm_pkg::N_IND-1:0] led_q;
  logic disp_s1_q;
  logic disp_s2_q;
  logic [tsm_pkg::N_EXT-1:0] ext_s1_q;
  logic [tsm_pkg::N_EXT-1:0] ext_s2_q;

  // Packing of time and equation fields into bus words
  function automatic logic [31:0] pack_hms(input tsm_pkg::tsm_hms_t v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tsm_pkg::HOUR_LSB +: 5] = v.hour;
    w[tsm_pkg::MIN_LSB +: 6] = v.min;
    w[tsm_pkg::SEC_LSB +: 6] = v.sec;
    return w;
  endfunction : pack_hms

  function automatic tsm_pkg::tsm_hms_t unpack_hms(input logic [31:0] w);
    tsm_pkg::tsm_hms_t v;
    v.hour = w[tsm_pkg::HOUR_LSB +: 5];
    v.min = w[tsm_pkg::MIN_LSB +: 6];
    v.sec = w[tsm_pkg::SEC_LSB +: 6];
    return v;
  endfunction : unpack_hms

  function automatic logic hms_legal(input tsm_pkg::tsm_hms_t v);
    return (v.hour <= tsm_pkg::HOUR_MAX) && (v.min <= tsm_pkg::MIN_MAX) &&
      (v.sec <= tsm_pkg::SEC_MAX);
  endfunction : hms_legal

  function automatic logic [31:0] pack_eqn(input tsm_pkg::tsm_eqn_t e);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[tsm_pkg::SEL_A_LSB +: tsm_pkg::SRC_W] = e.sel_a;
    w[tsm_pkg::SEL_B_LSB +: tsm_pkg::SRC_W] = e.sel_b;
    w[tsm_pkg::SEL_C_LSB +: tsm_pkg::SRC_W] = e.sel_c;
    w[tsm_pkg::INV_LSB +: 3] = e.inv;
    return w;
  endfunction : pack_eqn

  function automatic tsm_pkg::tsm_eqn_t unpack_eqn(input logic [31:0] w);
    tsm_pkg::tsm_eqn_t e;
    e.sel_a = w[tsm_pkg::SEL_A_LSB +: tsm_pkg::SRC_W];
    e.sel_b = w[tsm_pkg::SEL_B_LSB +: tsm_pkg::SRC_W];
    e.sel_c = w[tsm_pkg::SEL_C_LSB +: tsm_pkg::SRC_W];
    e.inv = w[tsm_pkg::INV_LSB +: 3];
    return e;
  endfunction : unpack_eqn

  // Byte lane merge of a write into the current word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] w;
    w = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        w[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return w;
  endfunction : merge

  // Equation register index, or N_EQN when not an equation address
  function automatic int eqn_index(input logic [7:0] a);
    int idx;
    idx = tsm_pkg::N_EQN;
    if (a >= tsm_pkg::EQN_BASE && a[1:0] == 2'h0) begin
      idx = int'(a - tsm_pkg::EQN_BASE) >> 2;
      if (idx > tsm_pkg::N_EQN) begin
        idx = tsm_pkg::N_EQN;
      end
    end
    return idx;
  endfunction : eqn_index

  // Read mux over the whole map; shared by the read channel and the write merge
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    logic [32:0] r;
    int ei;
    r = {1'b0, 32'h0000_0000};
    ei = eqn_index(a);
    if (a == tsm_pkg::DAILY0_OFF) begin
      r = {1'b1, pack_hms(daily_q[0])};
    end else if (a == tsm_pkg::DAILY1_OFF) begin
      r = {1'b1, pack_hms(daily_q[1])};
    end else if (a == tsm_pkg::ACTIVE_OFF) begin
      r = {1'b1, pack_hms('{hour: act_q.hour, min: act_q.min, sec: act_q.sec})};
      r[tsm_pkg::DAY_LSB +: 5] = act_q.day;
    end else if (a == tsm_pkg::WEEK_OFF) begin
      r = {1'b1, 25'h000_0000, week_en_q};
    end else if (a == tsm_pkg::STATUS_OFF) begin
      r = {1'b1, 32'h0000_0000};
      r[tsm_pkg::ST_SP_LSB +: 7] = sp_q;
      r[tsm_pkg::ST_AUX_LSB +: tsm_pkg::N_AUX] = flag_q[tsm_pkg::N_AUX-1:0];
      r[tsm_pkg::ST_LINK_LSB +: tsm_pkg::N_LINK] =
        flag_q[tsm_pkg::N_AUX +: tsm_pkg::N_LINK];
      r[tsm_pkg::ST_IND_LSB +: tsm_pkg::N_IND] =
        flag_q[tsm_pkg::N_AUX + tsm_pkg::N_LINK +: tsm_pkg::N_IND];
    end else if (a == tsm_pkg::TIME_OFF) begin
      r = {1'b1, pack_hms('{hour: cal.hour, min: cal.min, sec: cal.sec})};
      r[tsm_pkg::DAY_LSB +: 5] = cal.day;
      r[tsm_pkg::WDAY_LSB +: 3] = cal.wday;
    end else if (ei < tsm_pkg::N_EQN) begin
      r = {1'b1, pack_eqn(eqn_q[ei])};
    end
    return r;
  endfunction : reg_word

  // Write decode: merged word, target and legality
  logic wr_fire;
  logic [32:0] wr_cur;
  logic [31:0] wr_word;
  tsm_pkg::tsm_hms_t wr_hms;
  logic [4:0] wr_day;
  int wr_eqn;
  logic wr_daily0;
  logic wr_daily1;
  logic wr_active;
  logic wr_week;
  logic wr_is_eqn;
  logic wr_legal;

  assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;
  always_comb wr_cur = reg_word(awaddr_q); // Process sees the registers the mux reads
  assign wr_word = merge(wr_cur[31:0], wdata_q, wstrb_q);
  assign wr_hms = unpack_hms(wr_word);
  assign wr_day = wr_word[tsm_pkg::DAY_LSB +: 5];
  assign wr_eqn = eqn_index(awaddr_q);
  assign wr_daily0 = awaddr_q == tsm_pkg::DAILY0_OFF;
  assign wr_daily1 = awaddr_q == tsm_pkg::DAILY1_OFF;
  assign wr_active = awaddr_q == tsm_pkg::ACTIVE_OFF;
  assign wr_week = awaddr_q == tsm_pkg::WEEK_OFF;
  assign wr_is_eqn = wr_eqn < tsm_pkg::N_EQN;
  // Out-of-range times are refused whole, so a half-valid setting never lands
  assign wr_legal = ((wr_daily0 | wr_daily1) & hms_legal(wr_hms)) | // [RL2] [RL3] [RL4]
    (wr_active & hms_legal(wr_hms) & (wr_day >= tsm_pkg::DAY_MIN)) | // [RL5] [RL6] [RL7] [RL8]
    wr_week | wr_is_eqn;

  // Write address and data slots; taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= tsm_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_q) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      aw_full_q <= ~wr_fire & (aw_full_q | (s_axi_awvalid & awready_q));
      w_full_q <= ~wr_fire & (w_full_q | (s_axi_wvalid & wready_q));
      awready_q <= ~(aw_full_q | (s_axi_awvalid & awready_q)) | wr_fire;
      wready_q <= ~(w_full_q | (s_axi_wvalid & wready_q)) | wr_fire;
      bvalid_q <= wr_fire | (bvalid_q & ~s_axi_bready);
      if (wr_fire) begin
        bresp_q <= wr_legal ? tsm_pkg::RESP_OKAY : tsm_pkg::RESP_SLVERR;
      end
    end
  end

  // Configuration registers; writes land on the response cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      daily_q[0] <= '{hour: tsm_pkg::DAILY0_HOUR_RST, min: tsm_pkg::DAILY_MIN_RST,
                      sec: tsm_pkg::DAILY_SEC_RST}; // [RL2] [RL3] [RL4]
      daily_q[1] <= '{hour: tsm_pkg::DAILY1_HOUR_RST, min: tsm_pkg::DAILY_MIN_RST,
                      sec: tsm_pkg::DAILY_SEC_RST}; // [RL2]
      act_q <= '{day: tsm_pkg::ACT_DAY_RST, hour: tsm_pkg::ACT_HOUR_RST,
                 min: tsm_pkg::ACT_MIN_RST, sec: tsm_pkg::ACT_SEC_RST}; // [RL5] [RL6] [RL7] [RL8]
      week_en_q <= tsm_pkg::WEEK_EN_RST; // [RL11] [RL12]
      for (int i = 0; i < tsm_pkg::N_EQN; i++) begin
        eqn_q[i] <= tsm_pkg::EQN_RST; // [RL13]
      end
    end else if (wr_fire && wr_legal) begin
      if (wr_daily0) begin
        daily_q[0] <= wr_hms;
      end else if (wr_daily1) begin
        daily_q[1] <= wr_hms;
      end else if (wr_active) begin
        act_q <= '{day: wr_day, hour: wr_hms.hour, min: wr_hms.min, sec: wr_hms.sec};
      end else if (wr_week) begin
        week_en_q <= wr_word[6:0]; // [RL11]
      end else if (wr_is_eqn) begin
        eqn_q[wr_eqn] <= unpack_eqn(wr_word);
      end
    end
  end

  // Read channel: one read at a time, answer one cycle after the address
  logic [32:0] rd_word;
  logic ar_take;

  always_comb rd_word = reg_word(s_axi_araddr);
  assign ar_take = s_axi_arvalid & arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= tsm_pkg::RESP_OKAY;
    end else begin
      rvalid_q <= ar_take | (rvalid_q & ~s_axi_rready);
      arready_q <= ~(ar_take | (rvalid_q & ~s_axi_rready));
      if (ar_take) begin
        rdata_q <= rd_word[31:0];
        rresp_q <= rd_word[32] ? tsm_pkg::RESP_OKAY : tsm_pkg::RESP_SLVERR;
      end
    end
  end

  // Setpoint compares against the live calendar, every clock
  logic [1:0] daily_hit;
  tsm_pkg::tsm_sp_out_t sp_d;

  assign daily_hit[0] = (cal.hour == daily_q[0].hour) && (cal.min == daily_q[0].min) &&
    (cal.sec == daily_q[0].sec); // [RL1] [RL16]
  assign daily_hit[1] = (cal.hour == daily_q[1].hour) && (cal.min == daily_q[1].min) &&
    (cal.sec == daily_q[1].sec); // [RL1] [RL16]
  // A match lasts a whole second; the edge makes it one pulse a day
  assign sp_d.daily_pulse = daily_hit & ~daily_hit_q; // [RL1]
  assign sp_d.act_day = cal.day == act_q.day; // [RL5]
  assign sp_d.act_hour = cal.hour == act_q.hour; // [RL6]
  assign sp_d.act_min = cal.min == act_q.min; // [RL7]
  assign sp_d.act_sec = cal.sec == act_q.sec; // [RL8]
  // Weekday codes above six are not days and never match
  assign sp_d.weekly = (cal.wday < 3'h7) && week_en_q[cal.wday]; // [RL10]

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      daily_hit_q <= 2'h0;
      sp_q <= '0;
    end else begin
      daily_hit_q <= daily_hit;
      sp_q <= sp_d; // [RL9] [RL16]
    end
  end

  // Pin synchronisers for the variant strap and the discrete inputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_s1_q <= 1'b0;
      disp_s2_q <= 1'b0;
      ext_s1_q <= '0;
      ext_s2_q <= '0;
    end else begin
      disp_s1_q <= display_variant;
      disp_s2_q <= disp_s1_q;
      ext_s1_q <= eng_in;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Equation sources: registers and constants only, so flags may feed each other safely
  logic [tsm_pkg::SRC_N-1:0] src;
  logic [tsm_pkg::N_EQN-1:0] flag_d;

  assign src[tsm_pkg::SRC_FALSE] = 1'b0;
  assign src[tsm_pkg::SRC_TRUE] = 1'b1;
  assign src[tsm_pkg::SRC_SP +: 7] = sp_q; // [RL9]
  assign src[tsm_pkg::SRC_EXT +: tsm_pkg::N_EXT] = ext_s2_q;
  assign src[tsm_pkg::SRC_FLAG +: tsm_pkg::N_EQN] = flag_q; // [RL13]
  assign src[tsm_pkg::SRC_N-1:tsm_pkg::SRC_FLAG + tsm_pkg::N_EQN] = '0;

  // Aux, shared link and indicator flags, one equation each
  for (genvar g = 0; g < tsm_pkg::N_EQN; g++) begin : g_eqn
    tsm_eqn u_eqn (
      .cfg(eqn_q[g]),
      .src(src),
      .result(flag_d[g])
    ); // [RL13] [RL15]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= '0;
      led_q <= '0;
    end else begin
      flag_q <= flag_d;
      // Display variant keeps the indicators as plain flags, LEDs dark
      led_q <= disp_s2_q ? '0 :
        flag_d[tsm_pkg::N_AUX + tsm_pkg::N_LINK +: tsm_pkg::N_IND]; // [RL14]
    end
  end

  // Outputs, each straight from a register
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign sp_out = sp_q;
  assign aux_flag = flag_q[tsm_pkg::N_AUX-1:0];
  assign shared_link_flag_n = flag_q[tsm_pkg::N_AUX +: tsm_pkg::N_LINK];
  assign indicator_flag_n = flag_q[tsm_pkg::N_AUX + tsm_pkg::N_LINK +: tsm_pkg::N_IND]; // [RL15]
  assign led = led_q;

endmodule : tsm_top

/* testbench/tsm_top_asserts.sv */
// Checker for the setpoint matcher: pulse and level relations at its ports.
// Assumes the calendar and all ports share aclk; bound into tsm_top.
`timescale 1ns/1ns
module tsm_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input tsm_pkg::tsm_cal_t cal,
  input wire logic display_variant,
  input tsm_pkg::tsm_sp_out_t sp_out,
  input wire logic [tsm_pkg::N_IND-1:0] indicator_flag_n,
  input wire logic [tsm_pkg::N_IND-1:0] led
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A level may only move when its calendar field moved or a write landed
  property p_level(logic src_same, logic lvl);
    $past(aresetn) && src_same && !s_axi_bvalid |=> $stable(lvl);
  endproperty

  AST_PULSE_ONE: assert property (sp_out.daily_pulse != 2'h0 |=>
    (sp_out.daily_pulse & $past(sp_out.daily_pulse)) == 2'h0)
    else $error("daily pulse held longer than one cycle");
  AST_PULSE_CAUSE: assert property ($past(aresetn) && !s_axi_bvalid &&
    $stable({cal.hour, cal.min, cal.sec}) |=> sp_out.daily_pulse == 2'h0)
    else $error("daily pulse without a time change");
  AST_DAY_LEVEL: assert property (p_level($stable(cal.day), sp_out.act_day))
    else $error("active day moved within a day");
  AST_HOUR_LEVEL: assert property (p_level($stable(cal.hour), sp_out.act_hour))
    else $error("active hour moved within an hour");
  AST_MIN_LEVEL: assert property (p_level($stable(cal.min), sp_out.act_min))
    else $error("active minute moved within a minute");
  AST_SEC_LEVEL: assert property (p_level($stable(cal.sec), sp_out.act_sec))
    else $error("active second moved within a second");
  AST_WEEK_LEVEL: assert property (p_level($stable(cal.wday), sp_out.weekly))
    else $error("weekly output moved within a weekday");
  AST_LED_OFF: assert property (display_variant [*4] |=> led == 8'h00)
    else $error("led driven on the display variant");
  AST_LED_SHOW: assert property (!display_variant [*4] |=> led == indicator_flag_n)
    else $error("led differs from indicator flags");

  // Main scenarios reached
  COV_PULSE0: cover property (sp_out.daily_pulse[0]);
  COV_PULSE1: cover property (sp_out.daily_pulse[1]);
  COV_DAY_WEEK: cover property (sp_out.act_day && sp_out.weekly);
endmodule : tsm_top_asserts

bind tsm_top tsm_top_asserts i_asserts (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .cal(cal), .display_variant(display_variant),
  .sp_out(sp_out), .indicator_flag_n(indicator_flag_n), .led(led));

/* testbench/tsm_eng_model.sv */
// Equation engine stand-in: counts daily pulses and forms a combined window.
// Assumes sp_out is registered on aclk by the matcher.
`timescale 1ns/1ns
module tsm_eng_model (
  input wire logic aclk,
  input wire logic aresetn,
  input tsm_pkg::tsm_sp_out_t sp_out,
  output logic [7:0] pulse_cnt0_q,
  output logic [7:0] pulse_cnt1_q,
  output logic window
);
  // Day and hour combined into one window of the whole hour
  assign window = sp_out.act_day & sp_out.act_hour;

  // Each pulse is one event; a stretched pulse would count twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_cnt0_q <= 8'h00;
      pulse_cnt1_q <= 8'h00;
    end else begin
      pulse_cnt0_q <= pulse_cnt0_q + {7'h00, sp_out.daily_pulse[0]};
      pulse_cnt1_q <= pulse_cnt1_q + {7'h00, sp_out.daily_pulse[1]};
    end
  end
endmodule : tsm_eng_model

/* testbench/tsm_top_tb.sv */
// Self-checking bench for the setpoint matcher, driven over its register bus.
// Assumes registered AXI4-Lite handshakes and a calendar on the same clock.
`timescale 1ns/1ns
module tsm_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, display_variant = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  tsm_pkg::tsm_cal_t cal = {5'h02, 3'h6, 5'h03, 6'h1E, 6'h1E};
  logic [tsm_pkg::N_EXT-1:0] eng_in = 7'h00;
  tsm_pkg::tsm_sp_out_t sp_out;
  logic [tsm_pkg::N_AUX-1:0] aux_flag;
  logic [tsm_pkg::N_LINK-1:0] shared_link_flag_n;
  logic [tsm_pkg::N_IND-1:0] indicator_flag_n, led;
  logic [7:0] pulse_cnt0, pulse_cnt1;
  logic window;
  int miscompares = 0;
  int samples_checked = 0;

  tsm_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cal, .eng_in, .display_variant, .sp_out,
    .aux_flag, .shared_link_flag_n, .indicator_flag_n, .led);
  tsm_eng_model i_eng (.aclk, .aresetn, .sp_out, .pulse_cnt0_q(pulse_cnt0),
    .pulse_cnt1_q(pulse_cnt1), .window);

  // 250 MHz clock
  always #2 aclk = ~aclk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  // Write: address and data offered together, each released when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit got;
    n = 0;
    got = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got && n < 64) begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", 32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) miscompares++;
    // An edge between calls, so bready is never set twice at once
    @(posedge aclk);
  endtask : axw

  // Read: rready held until the answer is sampled
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    bit got;
    n = 0;
    got = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got && n < 64) begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", 32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        got = 1'b1;
      end
    end
    if (!got) miscompares++;
    @(posedge aclk);
  endtask : axr

  // Calendar step; outputs follow one cycle later, three allowed
  task automatic setcal(input int d, input int w, input int h, input int m, input int s);
    cal <= {5'(d), 3'(w), 5'(h), 6'(m), 6'(s)};
    repeat (3) @(posedge aclk);
  endtask : setcal

  task automatic act(input int d, input int w, input int h, input int m, input int s,
                     input logic [4:0] e);
    setcal(d, w, h, m, s);
    chk("weekly and active", 32'(sp_out[6:2]), 32'(e));
  endtask : act

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    miscompares++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // Reset values, unmapped place
    axr(8'h00, 32'h0008_0000, 2'h0);
    axr(8'h04, 32'h0011_0000, 2'h0);
    axr(8'h08, 32'h010C_0000, 2'h0);
    axr(8'h0C, 32'h0000_001F, 2'h0);
    axr(8'h30, 32'h0000_0000, 2'h2);
    chk("aux", 32'(aux_flag), 32'h0000_0000);
    $display("test reset values done");
    // Out of range refused and register kept, boundaries accepted
    axw(8'h00, 32'h0018_0000, 2'h2);
    axw(8'h04, 32'h0000_3C00, 2'h2);
    axw(8'h04, 32'h0000_003C, 2'h2);
    axw(8'h08, 32'h000C_0000, 2'h2);
    axw(8'h10, 32'h0000_0000, 2'h2);
    axr(8'h00, 32'h0008_0000, 2'h0);
    axw(8'h00, 32'h0017_3B3B, 2'h0);
    axr(8'h00, 32'h0017_3B3B, 2'h0);
    $display("test ranges done");
    // Daily pulses: once per match, held time gives no second pulse
    setcal(2, 6, 23, 59, 58);
    setcal(2, 6, 23, 59, 59);
    repeat (5) @(posedge aclk);
    chk("pulse0", 32'(pulse_cnt0), 32'h0000_0001);
    setcal(3, 0, 17, 0, 0);
    chk("pulse1", 32'(pulse_cnt1), 32'h0000_0001);
    chk("pulse0", 32'(pulse_cnt0), 32'h0000_0001);
    $display("test daily done");
    // Active setpoints at day 31 23:59:59, edges of each window
    axw(8'h08, 32'h1F17_3B3B, 2'h0);
    act(31, 0, 23, 59, 59, 5'h1F);
    act(31, 5, 23, 0, 0, 5'h03);
    chk("window", 32'(window), 32'h0000_0001);
    axr(8'h10, 32'h0000_000C, 2'h0);
    axr(8'h14, 32'h1FB7_0000, 2'h0);
    act(30, 4, 10, 59, 0, 5'h14);
    act(1, 6, 0, 0, 59, 5'h08);
    act(31, 6, 0, 0, 0, 5'h01);
    // Weekdays with reset enables, then weekend only
    for (int p = 0; p < 2; p++) begin
      if (p == 1) axw(8'h0C, 32'h0000_0060, 2'h0);
      for (int w = 0; w < 7; w++) begin
        setcal(10, w, 5, 5, 5);
        chk("weekly", 32'(sp_out.weekly), (p == 1) ? 32'(w >= 5) : 32'(w < 5));
      end
    end
    $display("test active and weekly done");
    // Equations: true, discrete input, inverted false, active day
    setcal(31, 0, 1, 1, 1);
    axw(8'h40, 32'h0001_0101, 2'h0);
    axw(8'h44, 32'h0001_0109, 2'h0);
    axw(8'h60, 32'h0101_0100, 2'h0);
    axw(8'h74, 32'h0001_0104, 2'h0);
    axw(8'h94, 32'h0001_0101, 2'h2);
    eng_in <= 7'h01;
    repeat (6) @(posedge aclk);
    chk("aux", 32'(aux_flag), 32'h0000_0003);
    chk("link", 32'(shared_link_flag_n), 32'h0000_0001);
    chk("indicator", 32'(indicator_flag_n), 32'h0000_0001);
    chk("led", 32'(led), 32'h0000_0001);
    display_variant <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("led", 32'(led), 32'h0000_0000);
    chk("indicator", 32'(indicator_flag_n), 32'h0000_0001);
    $display("test flags done");
    close_out();
  end
endmodule : tsm_top_tb
